// file: include/strap_pins_defines.vh
// Purpose: constants for the strap and status pin block
// Assumes: 32-bit AXI4-Lite register words, byte addresses
// Notes: none
`ifndef STRAP_PINS_DEFINES_VH
`define STRAP_PINS_DEFINES_VH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define REG_STRAPS 5'h00
`define REG_FEATURE 5'h04
`define REG_CHARGE_CFG 5'h08
`define REG_LINK_STATE 5'h0c
`define REG_IRQ_STATUS 5'h10
`define REG_IRQ_MASK 5'h14

// ----------------------------------------
// Field positions
// ----------------------------------------
`define STRAP_GANGED 0
`define STRAP_AUTO_N 1
`define STRAP_BUS_MODE 2
`define STRAP_PWR_N 3
`define FEAT_LINK_OUT 0
`define FEAT_SLEEP_OUT 1
`define CHG_AUTO_DIS 0
`define CHG_AUTO_ON 1
`define CHG_PORT1_CDP 2
`define IRQ_LINK_CHG 0
`define IRQ_SLEEP_CHG 1

// ----------------------------------------
// Reset values and responses
// ----------------------------------------
`define FEATURE_RST 2'h0
`define MASK_RST 2'h0
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// file: rtl/strap_status_pins.v
// Purpose: strap capture and post-reset status output on two dual-function pins
// Assumes: pins synchronous to aclk; synchronous active-low reset
// Notes: registers on AXI4-Lite; interrupt on status changes
//
// Operation
// - Latch grouping strap at reset release: low per-port, high grouped power control.
// - In SMBus mode, target address bit 2 follows the grouping strap level.
// - When enabled after reset, grouping pin drives upstream high-speed link flag.
// - Latch auto-charge strap: low enables automatic charging when unconnected, high disables.
// - In automatic charging mode, port 1 offers no charging-downstream-port behaviour.
// - Latched auto-charge strap loads the auto-charge disable bit of charge config.
// - When enabled after reset, auto-charge pin drives upstream high-speed sleep flag.
// - Latch bus-mode strap: low SMBus target mode, high serial EEPROM master.
// - Latch power-switching strap: low enables switching and over-current inputs.
//
// The placing of the registers and the AXI4-Lite slave port were decided locally.
`timescale 1ns/1ps
`include "strap_pins_defines.vh"

module strap_status_pins
(
	input wire aclk,
	input wire aresetn,
	input wire s_axi_awvalid,
	output reg s_axi_awready,
	input wire [4:0] s_axi_awaddr,
	input wire [2:0] s_axi_awprot,
	input wire s_axi_wvalid,
	output reg s_axi_wready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	output reg [1:0] s_axi_bresp,
	input wire s_axi_arvalid,
	output reg s_axi_arready,
	input wire [4:0] s_axi_araddr,
	input wire [2:0] s_axi_arprot,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	input wire target_addr_bit2_strap_i,
	output reg target_addr_bit2_strap_o,
	output reg target_addr_bit2_strap_oe,
	input wire auto_charge_strap_n_i,
	output reg auto_charge_strap_n_o,
	output reg auto_charge_strap_n_oe,
	input wire bus_mode_strap,
	input wire port_power_switching_strap_n,
	input wire upstream_highspeed_link_flag,
	input wire upstream_highspeed_sleep_flag,
	input wire hub_connected,
	output reg ganged_power_q,
	output reg power_switching_en_q,
	output reg smbus_mode_q,
	output reg target_addr_bit2_q,
	output reg auto_charge_on_q,
	output reg port1_cdp_allowed_q,
	output reg irq
);

	// ----------------------------------------
	// Strap capture
	// ----------------------------------------
	reg in_reset_q;
	reg [3:0] straps_q;
	reg [1:0] feature_q;
	reg auto_dis_q;
	reg [1:0] irq_status_q;
	reg [1:0] irq_mask_q;
	reg link_prev_q;
	reg sleep_prev_q;

	// in_reset_q is still high at the first edge after release: that edge is the one strap sample

	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			in_reset_q <= 1'b1;
			straps_q <= 4'h0;
		end
		else
		begin
			in_reset_q <= 1'b0;
			if (in_reset_q)
			begin
				straps_q[`STRAP_GANGED] <= target_addr_bit2_strap_i;
				straps_q[`STRAP_AUTO_N] <= auto_charge_strap_n_i;
				straps_q[`STRAP_BUS_MODE] <= bus_mode_strap;
				straps_q[`STRAP_PWR_N] <= port_power_switching_strap_n;
			end
		end
	end

	// ----------------------------------------
	// Decoded modes
	// ----------------------------------------
	// Grouping only counts while power switching is enabled; the address bit only in SMBus mode
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			ganged_power_q <= 1'b0;
			power_switching_en_q <= 1'b0;
			smbus_mode_q <= 1'b0;
			target_addr_bit2_q <= 1'b0;
			auto_charge_on_q <= 1'b0;
			port1_cdp_allowed_q <= 1'b0;
		end
		else
		begin
			power_switching_en_q <= ~straps_q[`STRAP_PWR_N];
			ganged_power_q <= straps_q[`STRAP_GANGED] & ~straps_q[`STRAP_PWR_N];
			smbus_mode_q <= ~straps_q[`STRAP_BUS_MODE];
			target_addr_bit2_q <= ~straps_q[`STRAP_BUS_MODE] & straps_q[`STRAP_GANGED];
			auto_charge_on_q <= ~auto_dis_q & ~hub_connected;
			port1_cdp_allowed_q <= auto_dis_q;
		end
	end

	// ----------------------------------------
	// Pin drive
	// ----------------------------------------
	// The pin level is prepared every cycle; only the enable decides whether it reaches the pin
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			target_addr_bit2_strap_o <= 1'b0;
			target_addr_bit2_strap_oe <= 1'b0;
			auto_charge_strap_n_o <= 1'b0;
			auto_charge_strap_n_oe <= 1'b0;
		end
		else
		begin
			target_addr_bit2_strap_oe <= ~in_reset_q & feature_q[`FEAT_LINK_OUT];
			target_addr_bit2_strap_o <= upstream_highspeed_link_flag;
			auto_charge_strap_n_oe <= ~in_reset_q & feature_q[`FEAT_SLEEP_OUT];
			auto_charge_strap_n_o <= upstream_highspeed_sleep_flag;
		end
	end

	// ----------------------------------------
	// AXI4-Lite write channel
	// ----------------------------------------
	// Writable words; every other address answers with an error and changes nothing
	function reg_writable;
		input [4:0] addr;
		begin
			reg_writable = (addr == `REG_FEATURE) || (addr == `REG_IRQ_MASK) || (addr == `REG_CHARGE_CFG);
		end
	endfunction

	reg [4:0] awaddr_q;
	reg aw_held_q;
	reg [31:0] wdata_q;
	reg w_held_q;
	wire do_write = aw_held_q && w_held_q && !s_axi_bvalid;
	wire wr_ok = reg_writable(awaddr_q);
	wire wr_feature = do_write && (awaddr_q == `REG_FEATURE);
	wire wr_mask = do_write && (awaddr_q == `REG_IRQ_MASK);
	wire wr_charge = do_write && (awaddr_q == `REG_CHARGE_CFG);

	// Address and data are taken independently; a held pair blocks both until it is answered
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `RESP_OKAY;
			awaddr_q <= 5'h0;
			aw_held_q <= 1'b0;
			wdata_q <= 32'h0;
			w_held_q <= 1'b0;
		end
		else
		begin
			s_axi_awready <= !aw_held_q && !s_axi_awready && s_axi_awvalid;
			if (s_axi_awvalid && s_axi_awready)
			begin
				awaddr_q <= s_axi_awaddr;
				aw_held_q <= 1'b1;
			end
			s_axi_wready <= !w_held_q && !s_axi_wready && s_axi_wvalid;
			if (s_axi_wvalid && s_axi_wready)
			begin
				wdata_q <= s_axi_wdata;
				w_held_q <= 1'b1;
			end
			if (do_write)
			begin
				aw_held_q <= 1'b0;
				w_held_q <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
			end
			else if (s_axi_bvalid && s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
	end

	// ----------------------------------------
	// Software registers
	// ----------------------------------------
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			feature_q <= `FEATURE_RST;
			irq_mask_q <= `MASK_RST;
			auto_dis_q <= 1'b0;
		end
		else
		begin
			if (wr_feature)
				feature_q <= wdata_q[1:0];
			if (wr_mask)
				irq_mask_q <= wdata_q[1:0];
			// Strap copy first; a later software write overrides it
			if (in_reset_q)
				auto_dis_q <= auto_charge_strap_n_i;
			else if (wr_charge)
				auto_dis_q <= wdata_q[`CHG_AUTO_DIS];
		end
	end

	// ----------------------------------------
	// AXI4-Lite read channel
	// ----------------------------------------
	reg [31:0] rd_d;
	reg rd_ok;
	wire do_read = s_axi_arvalid && s_axi_arready;
	wire rd_status = do_read && (s_axi_araddr == `REG_IRQ_STATUS);

	always @*
	begin
		rd_d = 32'h0;
		rd_ok = 1'b1;
		case (s_axi_araddr)
			`REG_STRAPS: rd_d[3:0] = straps_q;
			`REG_FEATURE: rd_d[1:0] = feature_q;
			`REG_CHARGE_CFG: rd_d[2:0] = {port1_cdp_allowed_q, auto_charge_on_q, auto_dis_q};
			`REG_LINK_STATE: rd_d[1:0] = {upstream_highspeed_sleep_flag, upstream_highspeed_link_flag};
			`REG_IRQ_STATUS: rd_d[1:0] = irq_status_q;
			`REG_IRQ_MASK: rd_d[1:0] = irq_mask_q;
			default: rd_ok = 1'b0;
		endcase
	end

	// A new address is taken only once the previous answer has been consumed
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0;
			s_axi_rresp <= `RESP_OKAY;
		end
		else
		begin
			s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
			if (do_read)
			begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= rd_d;
				s_axi_rresp <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
			end
			else if (s_axi_rvalid && s_axi_rready)
				s_axi_rvalid <= 1'b0;
		end
	end

	// ----------------------------------------
	// Interrupts
	// ----------------------------------------
	// Previous levels reset to the idle low level, so no false change follows reset
	wire [1:0] events = {sleep_prev_q ^ upstream_highspeed_sleep_flag,
		link_prev_q ^ upstream_highspeed_link_flag};
	// New events win over the read clear; the read still returns the old value
	wire [1:0] irq_status_d = (rd_status ? 2'h0 : irq_status_q) | events;

	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			irq_status_q <= 2'h0;
			link_prev_q <= 1'b0;
			sleep_prev_q <= 1'b0;
			irq <= 1'b0;
		end
		else
		begin
			link_prev_q <= upstream_highspeed_link_flag;
			sleep_prev_q <= upstream_highspeed_sleep_flag;
			irq_status_q <= irq_status_d;
			irq <= |(irq_status_d & irq_mask_q);
		end
	end

endmodule

// file: dv/strap_board.sv
// Purpose: board side of the two dual-function pins
// Assumes: straps are driven only while drive is high
// Notes: a released pin settles at its pull level
`timescale 1ns/1ps
module strap_board
(
	input wire drive,
	input wire [3:0] s,
	input wire target_addr_bit2_strap_o,
	input wire target_addr_bit2_strap_oe,
	input wire auto_charge_strap_n_o,
	input wire auto_charge_strap_n_oe,
	output wire target_addr_bit2_strap_i,
	output wire auto_charge_strap_n_i
);
// Grouping pin has a pull-down, auto-charge pin a pull-up
assign target_addr_bit2_strap_i = target_addr_bit2_strap_oe ? target_addr_bit2_strap_o : (drive & s[0]);
assign auto_charge_strap_n_i = auto_charge_strap_n_oe ? auto_charge_strap_n_o : (!drive | s[1]);
endmodule

// file: dv/strap_pins_sva.sv
// Purpose: concurrent checks on strap capture and status pins
// Assumes: one clock, synchronous active-low reset
// Notes: cnt_q counts edges since reset release, saturating at 3
`timescale 1ns/1ps
module strap_pins_sva
(
	input wire aclk,
	input wire aresetn,
	input wire target_addr_bit2_strap_o,
	input wire target_addr_bit2_strap_oe,
	input wire auto_charge_strap_n_o,
	input wire auto_charge_strap_n_oe,
	input wire upstream_highspeed_link_flag,
	input wire upstream_highspeed_sleep_flag,
	input wire ganged_power_q,
	input wire power_switching_en_q,
	input wire smbus_mode_q,
	input wire target_addr_bit2_q,
	input wire auto_charge_on_q,
	input wire port1_cdp_allowed_q
);
reg [1:0] cnt_q;
always @(posedge aclk)
	cnt_q <= aresetn ? cnt_q + (cnt_q != 2'h3) : 2'h0;
default clocking @(posedge aclk); endclocking
default disable iff (!aresetn);
oe_in_reset_a: assert property (disable iff (1'h0)
	!aresetn |=> !target_addr_bit2_strap_oe && !auto_charge_strap_n_oe) else $error("pin driven in reset");
oe_late_a: assert property (target_addr_bit2_strap_oe || auto_charge_strap_n_oe |-> cnt_q >= 2'h2)
	else $error("pin driven too early");
link_out_a: assert property (target_addr_bit2_strap_oe |->
	target_addr_bit2_strap_o == $past(upstream_highspeed_link_flag)) else $error("link pin wrong");
sleep_out_a: assert property (auto_charge_strap_n_oe |->
	auto_charge_strap_n_o == $past(upstream_highspeed_sleep_flag)) else $error("sleep pin wrong");
straps_hold_a: assert property (cnt_q == 2'h3 |->
	$stable({ganged_power_q, power_switching_en_q, smbus_mode_q, target_addr_bit2_q})) else $error("strap moved");
ganged_pwr_a: assert property (ganged_power_q |-> power_switching_en_q) else $error("ganged no switch");
addr_smbus_a: assert property (target_addr_bit2_q |-> smbus_mode_q) else $error("addr bit no smbus");
cdp_auto_a: assert property (auto_charge_on_q |-> !port1_cdp_allowed_q) else $error("port1 cdp in auto");
endmodule
bind strap_status_pins strap_pins_sva u_sva (.aclk(aclk), .aresetn(aresetn),
	.target_addr_bit2_strap_o(target_addr_bit2_strap_o), .target_addr_bit2_strap_oe(target_addr_bit2_strap_oe),
	.auto_charge_strap_n_o(auto_charge_strap_n_o), .auto_charge_strap_n_oe(auto_charge_strap_n_oe),
	.upstream_highspeed_link_flag(upstream_highspeed_link_flag),
	.upstream_highspeed_sleep_flag(upstream_highspeed_sleep_flag),
	.ganged_power_q(ganged_power_q), .power_switching_en_q(power_switching_en_q), .smbus_mode_q(smbus_mode_q),
	.target_addr_bit2_q(target_addr_bit2_q), .auto_charge_on_q(auto_charge_on_q),
	.port1_cdp_allowed_q(port1_cdp_allowed_q));

// file: dv/tb_strap_status_pins.sv
// Purpose: bench for strap_status_pins
// Assumes: board model drives straps during reset
// Notes: walks 12 of 16 strap codes (grouping strap high only with auto-charge strap high), then pin status
`timescale 1ns/1ps
module tb_strap_status_pins;
reg aclk = 1'h0, aresetn = 1'h0, s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
reg s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, drive = 1'h1, hub_connected = 1'h0;
reg upstream_highspeed_link_flag = 1'h0, upstream_highspeed_sleep_flag = 1'h0;
reg [4:0] s_axi_awaddr = 5'h0, s_axi_araddr = 5'h0;
reg [31:0] s_axi_wdata = 32'h0;
reg [3:0] s = 4'h0, s_axi_wstrb = 4'hf;
reg [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
integer n_mismatch = 0, checks_done = 0, i;
wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
wire [1:0] s_axi_bresp, s_axi_rresp;
wire [31:0] s_axi_rdata;
wire target_addr_bit2_strap_i, target_addr_bit2_strap_o, target_addr_bit2_strap_oe;
wire auto_charge_strap_n_i, auto_charge_strap_n_o, auto_charge_strap_n_oe;
wire ganged_power_q, power_switching_en_q, smbus_mode_q, target_addr_bit2_q, auto_charge_on_q, port1_cdp_allowed_q;
wire bus_mode_strap = s[2];
wire port_power_switching_strap_n = s[3];
always #2.5 aclk = ~aclk;
strap_status_pins dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
	.s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(s_axi_awprot), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
	.s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
	.s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
	.s_axi_araddr(s_axi_araddr), .s_axi_arprot(s_axi_arprot), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
	.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .target_addr_bit2_strap_i(target_addr_bit2_strap_i),
	.target_addr_bit2_strap_o(target_addr_bit2_strap_o), .target_addr_bit2_strap_oe(target_addr_bit2_strap_oe),
	.auto_charge_strap_n_i(auto_charge_strap_n_i), .auto_charge_strap_n_o(auto_charge_strap_n_o),
	.auto_charge_strap_n_oe(auto_charge_strap_n_oe), .bus_mode_strap(bus_mode_strap),
	.port_power_switching_strap_n(port_power_switching_strap_n),
	.upstream_highspeed_link_flag(upstream_highspeed_link_flag),
	.upstream_highspeed_sleep_flag(upstream_highspeed_sleep_flag), .hub_connected(hub_connected),
	.ganged_power_q(ganged_power_q), .power_switching_en_q(power_switching_en_q), .smbus_mode_q(smbus_mode_q),
	.target_addr_bit2_q(target_addr_bit2_q), .auto_charge_on_q(auto_charge_on_q),
	.port1_cdp_allowed_q(port1_cdp_allowed_q), .irq(irq));
strap_board board (.drive(drive), .s(s), .target_addr_bit2_strap_o(target_addr_bit2_strap_o),
	.target_addr_bit2_strap_oe(target_addr_bit2_strap_oe), .auto_charge_strap_n_o(auto_charge_strap_n_o),
	.auto_charge_strap_n_oe(auto_charge_strap_n_oe), .target_addr_bit2_strap_i(target_addr_bit2_strap_i),
	.auto_charge_strap_n_i(auto_charge_strap_n_i));
task chk(input [31:0] g, input [31:0] e);
begin
	checks_done = checks_done + 1;
	if (g !== e)
	begin
		n_mismatch = n_mismatch + 1;
		$display("[ERR] t=%0t got %h exp %h", $time, g, e);
	end
end
endtask
task axw(input [4:0] a, input [31:0] d, input [1:0] r);
begin
	s_axi_awaddr <= a;
	s_axi_wdata <= d;
	s_axi_awvalid <= 1'h1;
	s_axi_wvalid <= 1'h1;
	s_axi_bready <= 1'h1;
	do
	begin
		@(posedge aclk);
		if (s_axi_awready)
			s_axi_awvalid <= 1'h0;
		if (s_axi_wready)
			s_axi_wvalid <= 1'h0;
	end
	while (s_axi_bvalid !== 1'h1);
	chk(s_axi_bresp, r);
	s_axi_bready <= 1'h0;
	@(posedge aclk);
end
endtask
task axr(input [4:0] a, input [31:0] e, input [1:0] r);
begin
	s_axi_araddr <= a;
	s_axi_arvalid <= 1'h1;
	s_axi_rready <= 1'h1;
	do
	begin
		@(posedge aclk);
		if (s_axi_arready)
			s_axi_arvalid <= 1'h0;
	end
	while (s_axi_rvalid !== 1'h1);
	chk(s_axi_rdata, e);
	chk(s_axi_rresp, r);
	s_axi_rready <= 1'h0;
	@(posedge aclk);
end
endtask
task report_and_stop;
begin
	$display("checks %0d mismatches %0d", checks_done, n_mismatch);
	if (n_mismatch == 0 && checks_done > 0)
		$display("RESULT: PASS");
	else
		$display("RESULT: FAIL");
	$finish;
end
endtask
initial
begin
	#20000;
	n_mismatch = n_mismatch + 1;
	report_and_stop;
end
initial
begin
	for (i = 0; i < 16; i = i + 1)
	begin
		@(posedge aclk);
		aresetn <= 1'h0;
		drive <= 1'h1;
		s <= {i[3:1], i[0] & i[1]};
		hub_connected <= i[0] ^ i[1];
		repeat (3) @(posedge aclk);
		aresetn <= 1'h1;
		repeat (2) @(posedge aclk);
		drive <= 1'h0;
		@(posedge aclk);
		chk({ganged_power_q, power_switching_en_q, smbus_mode_q, target_addr_bit2_q},
			{s[0] & !s[3], !s[3], !s[2], s[0] & !s[2]});
		chk({auto_charge_on_q, port1_cdp_allowed_q}, {!s[1] & !hub_connected, s[1]});
		chk({target_addr_bit2_strap_oe, auto_charge_strap_n_oe}, 2'h0);
		axr(5'h00, s, 2'h0);
		axr(5'h08, {s[1], !s[1] & !hub_connected, s[1]}, 2'h0);
		$display("strap code %h done", s);
	end
	axw(5'h00, 32'h0, 2'h2);
	axr(5'h18, 32'h0, 2'h2);
	axw(5'h14, 32'h1, 2'h0);
	axw(5'h04, 32'h3, 2'h0);
	upstream_highspeed_link_flag <= 1'h1;
	upstream_highspeed_sleep_flag <= 1'h1;
	repeat (3) @(posedge aclk);
	chk({target_addr_bit2_strap_oe, auto_charge_strap_n_oe, target_addr_bit2_strap_i, auto_charge_strap_n_i, irq},
		5'h1f);
	axr(5'h10, 32'h3, 2'h0);
	upstream_highspeed_sleep_flag <= 1'h0;
	repeat (3) @(posedge aclk);
	chk({irq, target_addr_bit2_strap_i, auto_charge_strap_n_i}, 3'h2);
	axw(5'h08, 32'h0, 2'h0);
	axr(5'h08, 32'h2, 2'h0);
	axw(5'h04, 32'h0, 2'h0);
	repeat (2) @(posedge aclk);
	chk({target_addr_bit2_strap_oe, auto_charge_strap_n_oe, target_addr_bit2_strap_i}, 3'h0);
	$display("pin status test done");
	report_and_stop;
end
endmodule
